// file: design/cfs_pkg.sv
`default_nettype none
package cfs_pkg;

  localparam int FIFO_COUNT = 32;

  // register byte offsets on the bus
  localparam logic [7:0] OFF_RX_PENDING = 8'h00;
  localparam logic [7:0] OFF_RX_OVERFLOW = 8'h04;
  localparam logic [7:0] OFF_TX_PENDING = 8'h08;
  localparam logic [7:0] OFF_TX_ATTEMPT = 8'h0c;
  localparam logic [7:0] OFF_SEND_REQUEST = 8'h10;
  localparam logic [7:0] OFF_MSG_MEM_BASE = 8'h14;
  localparam logic [7:0] OFF_TXQ_CONTROL = 8'h18;

  localparam logic [2:0] MODE_CONFIG = 3'h4;

  // reset values and the memory base alignment mask
  localparam logic [31:0] MSG_MEM_BASE_RST = 32'h0000_0000;
  localparam logic [31:0] SEND_REQUEST_RST = 32'h0000_0000;
  localparam logic [31:0] BASE_ALIGN_MASK = 32'hffff_fffc;
  localparam logic [1:0] RETRANSMIT_RST = 2'h3;
  localparam logic FIFO_RESET_RST = 1'b1;

  // transmit queue control field positions
  localparam int TXQ_PAYLOAD_LSB = 29;
  localparam int TXQ_DEPTH_LSB = 24;
  localparam int TXQ_RETX_LSB = 21;
  localparam int TXQ_PRIO_LSB = 16;
  localparam int TXQ_FIFO_RESET_BIT = 10;
  localparam int TXQ_SEND_BIT = 9;
  localparam int TXQ_INC_BIT = 8;
  localparam int TXQ_OBJECT_IS_TRANSMITTER_BIT = 7;
  localparam int TXQ_ATTEMPT_IE_BIT = 4;
  localparam int TXQ_EMPTY_IE_BIT = 2;
  localparam int TXQ_NOT_FULL_IE_BIT = 0;

  // per-FIFO flag and enable lines from the individual FIFO registers
  typedef struct packed {
    logic [2:0] rx_flags;
    logic [2:0] rx_enables;
    logic rx_overflow_pending;
    logic [2:0] tx_flags;
    logic [2:0] tx_enables;
    logic tx_attempt_pending;
  } cfs_fifo_flags_t;

  typedef struct packed {
    logic [2:0] payload_size;
    logic [4:0] fifo_depth;
    logic [1:0] retransmit_attempts;
    logic [4:0] transmit_priority;
    logic fifo_reset;
    logic attempt_ie;
    logic empty_ie;
    logic not_full_ie;
  } cfs_txq_ctrl_t;

  localparam cfs_txq_ctrl_t TXQ_CTRL_RST = '{
    payload_size: 3'h0,
    fifo_depth: 5'h00,
    retransmit_attempts: RETRANSMIT_RST,
    transmit_priority: 5'h00,
    fifo_reset: FIFO_RESET_RST,
    attempt_ie: 1'b0,
    empty_ie: 1'b0,
    not_full_ie: 1'b0
  };

  function automatic logic [31:0] byte_mask(input logic [3:0] sel);
    byte_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction : byte_mask

  function automatic logic reg_hit(input logic [7:0] adr, input logic [7:0] off);
    reg_hit = (adr[7:2] == off[7:2]);
  endfunction : reg_hit

endpackage : cfs_pkg
`default_nettype wire

// file: design/cfs_send_request.sv
`default_nettype none
module cfs_send_request (
  input wire logic clk,
  input wire logic rst,
  input wire logic [31:0] set_bits,
  input wire logic [31:0] object_is_transmitter,
  input wire logic [31:0] send_done,
  output logic [31:0] send_request
);
  import cfs_pkg::*;

  logic [31:0] tx_capable;
  logic [31:0] next_send_request;

  // the transmit queue is always a transmitter
  assign tx_capable = {object_is_transmitter[31:1], 1'b1};

  always_comb
  begin
    // a set arriving with the completion wins over the clear
    next_send_request = (send_request & ~send_done)
      | (set_bits & tx_capable);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      send_request <= SEND_REQUEST_RST;
    end
    else
    begin
      send_request <= next_send_request;
    end
  end

  req_set_a: assert property (@(posedge clk) disable iff (rst)
    |(set_bits & tx_capable) |=> ((send_request & $past(set_bits & tx_capable))
      == $past(set_bits & tx_capable)))
    else $error("requested transmit object did not latch");

  rx_no_set_a: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> ((send_request & ~$past(send_request) & ~$past(tx_capable)) == 32'h0000_0000))
    else $error("receive object request bit became set");

  no_abort_a: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> ((send_request & $past(send_request & ~send_done))
      == $past(send_request & ~send_done)))
    else $error("pending request dropped without completion");

  done_clear_a: assert property (@(posedge clk) disable iff (rst)
    |(send_done & ~set_bits) |=> ((send_request & $past(send_done & ~set_bits)) == 32'h0000_0000))
    else $error("completed request not cleared");

endmodule : cfs_send_request
`default_nettype wire

// file: design/cfs_summary.sv
`default_nettype none
module cfs_summary (
  input wire cfs_pkg::cfs_fifo_flags_t [31:0] fifo_flags,
  output logic [31:0] rx_pending,
  output logic [31:0] rx_overflow,
  output logic [31:0] tx_pending,
  output logic [31:0] tx_attempt
);
  import cfs_pkg::*;

  genvar n;
  generate
    for (n = 0; n < FIFO_COUNT; n++)
    begin : g_fifo
      if (n == 0)
      begin : g_queue
        // fifo 0 cannot receive; its transmit side is the transmit queue
        assign rx_pending[n] = 1'b0;
        assign rx_overflow[n] = 1'b0;
      end
      else
      begin : g_obj
        assign rx_pending[n] = |(fifo_flags[n].rx_flags & fifo_flags[n].rx_enables);
        assign rx_overflow[n] = fifo_flags[n].rx_overflow_pending;
      end
      assign tx_pending[n] = |(fifo_flags[n].tx_flags & fifo_flags[n].tx_enables);
      assign tx_attempt[n] = fifo_flags[n].tx_attempt_pending;
    end
  endgenerate

endmodule : cfs_summary
`default_nettype wire

// file: design/cfs_top.sv
// Notes on behaviour
// - Receive summary bits 31..1 are each the OR of FIFO n's enabled receive flags; bit 0 is 0.
// - A receive summary bit 31..1 is 1 exactly while an enabled receive flag of its FIFO is pending.
// - Overflow summary bits 31..1 mirror each FIFO's overflow flag, read-only, bit 0 is 0.
// - Each transmit summary bit is the OR of its transmit FIFO's enabled transmit flags.
// - Transmit summary bit 0 belongs to the transmit queue.
// - The attempt summary shows each FIFO's attempt-pending state, bit 0 for the queue.
// - Writing 1 to a transmitter's request bit starts sending; completion clears the bit.
// - Writing 0 to a request bit does nothing and never aborts a transmission.
// - Setting the request bit of a receive object has no effect.
// - Request bit 0 asks the transmit queue to send and self-clears on completion.
// - Request bit x maps onto message FIFO x.
// - The memory base locates the transmit event FIFO first, then the message objects.
// - The two low bits of the memory base always read zero.
// - The memory base takes writes only in configuration mode.
//
// The Wishbone slave port and the placing of the registers were decided locally.
`default_nettype none
module cfs_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [2:0] operating_mode_field,
  input wire cfs_pkg::cfs_fifo_flags_t [31:0] fifo_flags,
  input wire logic [31:0] object_is_transmitter,
  input wire logic [31:0] send_done,
  input wire logic fifo_reset_done,
  output logic [31:0] send_request,
  output logic [31:0] msg_mem_base,
  output cfs_pkg::cfs_txq_ctrl_t txq_ctrl,
  output logic head_tail_increment
);
  import cfs_pkg::*;

  logic [31:0] rx_pending;
  logic [31:0] rx_overflow;
  logic [31:0] tx_pending;
  logic [31:0] tx_attempt;
  logic [31:0] wmask;
  logic [31:0] req_set_bits;
  logic [31:0] read_value;
  logic [31:0] txq_word;
  logic cfg_mode;
  logic access;
  logic wr_fire;
  logic wr_req;
  logic wr_base;
  logic wr_txq;
  logic next_ack;
  logic [31:0] next_dat;
  logic [31:0] next_base;
  cfs_txq_ctrl_t next_txq;
  logic next_inc;

  cfs_summary u_summary (
    .fifo_flags(fifo_flags),
    .rx_pending(rx_pending),
    .rx_overflow(rx_overflow),
    .tx_pending(tx_pending),
    .tx_attempt(tx_attempt)
  );

  cfs_send_request u_send_request (
    .clk(clk),
    .rst(rst),
    .set_bits(req_set_bits),
    .object_is_transmitter(object_is_transmitter),
    .send_done(send_done),
    .send_request(send_request)
  );

  assign cfg_mode = (operating_mode_field == MODE_CONFIG);
  assign wmask = byte_mask(wb_sel_i);

  // request is sampled in the first cycle, answered one cycle later
  assign access = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  // writes take effect on the edge at which the master sees ack
  assign wr_fire = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;

  // summary offsets have no write strobe at all
  assign wr_req = wr_fire & reg_hit(wb_adr_i, OFF_SEND_REQUEST);
  assign wr_base = wr_fire & reg_hit(wb_adr_i, OFF_MSG_MEM_BASE);
  assign wr_txq = wr_fire & reg_hit(wb_adr_i, OFF_TXQ_CONTROL);

  // ones written set request bits; the queue also sets through its control word
  always_comb
  begin
    req_set_bits = 32'h0000_0000;
    if (wr_req)
    begin
      req_set_bits = wb_dat_i & wmask;
    end
    if (wr_txq && wb_sel_i[1] && wb_dat_i[TXQ_SEND_BIT])
    begin
      req_set_bits[0] = 1'b1;
    end
  end

  always_comb
  begin
    txq_word = 32'h0000_0000;
    txq_word[TXQ_PAYLOAD_LSB +: 3] = txq_ctrl.payload_size;
    txq_word[TXQ_DEPTH_LSB +: 5] = txq_ctrl.fifo_depth;
    txq_word[TXQ_RETX_LSB +: 2] = txq_ctrl.retransmit_attempts;
    txq_word[TXQ_PRIO_LSB +: 5] = txq_ctrl.transmit_priority;
    txq_word[TXQ_FIFO_RESET_BIT] = txq_ctrl.fifo_reset;
    txq_word[TXQ_SEND_BIT] = send_request[0];
    txq_word[TXQ_INC_BIT] = head_tail_increment;
    txq_word[TXQ_OBJECT_IS_TRANSMITTER_BIT] = 1'b1;
    txq_word[TXQ_ATTEMPT_IE_BIT] = txq_ctrl.attempt_ie;
    txq_word[TXQ_EMPTY_IE_BIT] = txq_ctrl.empty_ie;
    txq_word[TXQ_NOT_FULL_IE_BIT] = txq_ctrl.not_full_ie;
  end

  always_comb
  begin
    read_value = 32'h0000_0000;
    if (reg_hit(wb_adr_i, OFF_RX_PENDING))
    begin
      read_value = rx_pending;
    end
    else if (reg_hit(wb_adr_i, OFF_RX_OVERFLOW))
    begin
      read_value = rx_overflow;
    end
    else if (reg_hit(wb_adr_i, OFF_TX_PENDING))
    begin
      read_value = tx_pending;
    end
    else if (reg_hit(wb_adr_i, OFF_TX_ATTEMPT))
    begin
      read_value = tx_attempt;
    end
    else if (reg_hit(wb_adr_i, OFF_SEND_REQUEST))
    begin
      read_value = send_request;
    end
    else if (reg_hit(wb_adr_i, OFF_MSG_MEM_BASE))
    begin
      read_value = msg_mem_base;
    end
    else if (reg_hit(wb_adr_i, OFF_TXQ_CONTROL))
    begin
      read_value = txq_word;
    end
  end

  // bus answer group
  always_comb
  begin
    next_ack = access;
    next_dat = wb_dat_o;
    if (access && !wb_we_i)
    begin
      next_dat = read_value;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
    end
  end

  // message memory base: event FIFO first, objects after it
  always_comb
  begin
    next_base = msg_mem_base;
    if (wr_base && cfg_mode)
    begin
      next_base = ((msg_mem_base & ~wmask) | (wb_dat_i & wmask))
        & BASE_ALIGN_MASK;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      msg_mem_base <= MSG_MEM_BASE_RST;
    end
    else
    begin
      msg_mem_base <= next_base;
    end
  end

  // transmit queue control group
  always_comb
  begin
    next_txq = txq_ctrl;
    next_inc = 1'b0;
    if (fifo_reset_done)
    begin
      next_txq.fifo_reset = 1'b0;
    end
    if (wr_txq)
    begin
      if (cfg_mode && wb_sel_i[3])
      begin
        next_txq.payload_size = wb_dat_i[TXQ_PAYLOAD_LSB +: 3];
        next_txq.fifo_depth = wb_dat_i[TXQ_DEPTH_LSB +: 5];
      end
      if (wb_sel_i[2])
      begin
        next_txq.retransmit_attempts = wb_dat_i[TXQ_RETX_LSB +: 2];
        next_txq.transmit_priority = wb_dat_i[TXQ_PRIO_LSB +: 5];
      end
      if (wb_sel_i[1])
      begin
        // set wins over a completion arriving in the same cycle
        if (wb_dat_i[TXQ_FIFO_RESET_BIT])
        begin
          next_txq.fifo_reset = 1'b1;
        end
        next_inc = wb_dat_i[TXQ_INC_BIT];
      end
      if (wb_sel_i[0])
      begin
        next_txq.attempt_ie = wb_dat_i[TXQ_ATTEMPT_IE_BIT];
        next_txq.empty_ie = wb_dat_i[TXQ_EMPTY_IE_BIT];
        next_txq.not_full_ie = wb_dat_i[TXQ_NOT_FULL_IE_BIT];
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      txq_ctrl <= TXQ_CTRL_RST;
      head_tail_increment <= 1'b0;
    end
    else
    begin
      txq_ctrl <= next_txq;
      head_tail_increment <= next_inc;
    end
  end

  sequence bus_req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence

  sequence bus_ack_s;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  ack_once_a: assert property (@(posedge clk) disable iff (rst)
    bus_req_s |=> bus_ack_s)
    else $error("bus ack not a single cycle after request");

  base_align_a: assert property (@(posedge clk) disable iff (rst)
    msg_mem_base[1:0] == 2'h0)
    else $error("memory base low bits not zero");

  base_locked_a: assert property (@(posedge clk) disable iff (rst)
    (wr_base && !cfg_mode) |=> $stable(msg_mem_base))
    else $error("memory base changed outside configuration mode");

  base_write_a: assert property (@(posedge clk) disable iff (rst)
    (wr_base && cfg_mode && wb_sel_i == 4'hf) |=>
      (msg_mem_base == ($past(wb_dat_i) & BASE_ALIGN_MASK)))
    else $error("memory base write in configuration mode lost");

  rx_read_a: assert property (@(posedge clk) disable iff (rst)
    (bus_req_s ##0 (!wb_we_i && reg_hit(wb_adr_i, OFF_RX_PENDING))) |=>
      (wb_dat_o == $past(rx_pending)) && (wb_dat_o[0] == 1'b0))
    else $error("receive summary read mismatch");

  summary_ro_a: assert property (@(posedge clk) disable iff (rst)
    (wr_fire && (reg_hit(wb_adr_i, OFF_RX_PENDING) || reg_hit(wb_adr_i, OFF_TX_ATTEMPT)))
      |-> (req_set_bits == 32'h0000_0000))
    else $error("summary write reached request bits");

  txq_reset_a: assert property (@(posedge clk)
    $fell(rst) |-> (txq_ctrl.retransmit_attempts == RETRANSMIT_RST)
      && txq_ctrl.fifo_reset && !head_tail_increment && !send_request[0])
    else $error("queue control reset layout wrong");

  txq_send_a: assert property (@(posedge clk) disable iff (rst)
    (wr_txq && wb_sel_i[1] && wb_dat_i[TXQ_SEND_BIT]) |=> send_request[0])
    else $error("queue send bit did not request sending");

  inc_pulse_a: assert property (@(posedge clk) disable iff (rst)
    head_tail_increment |=> !head_tail_increment)
    else $error("increment not a single pulse");

endmodule : cfs_top
`default_nettype wire

// file: dv/cfs_fifo_model.sv
`default_nettype none
module cfs_fifo_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] done_delay,
  input wire logic [31:0] send_request,
  output logic [31:0] send_done
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic [31:0] next_done;
  // queued objects all finish together after done_delay+1 busy cycles
  always_comb
  begin
    next_cnt = 8'h00;
    next_done = 32'h0000_0000;
    if (send_request != 32'h0000_0000 && send_done == 32'h0000_0000)
    begin
      next_cnt = cnt + 8'h01;
      if (cnt >= done_delay)
      begin
        next_cnt = 8'h00;
        next_done = send_request;
      end
    end
  end
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt <= 8'h00;
      send_done <= 32'h0000_0000;
    end
    else
    begin
      cnt <= next_cnt;
      send_done <= next_done;
    end
  end
endmodule : cfs_fifo_model
`default_nettype wire

// file: dv/tb_canfd_fifo_status_and_tx_request.sv
`default_nettype none
module tb_canfd_fifo_status_and_tx_request;
  timeunit 1ns;
  timeprecision 1ns;
  import cfs_pkg::*;
  logic clk, rst, cyc, stb, we, ack, rst_done, hti;
  logic [7:0] adr, delay;
  logic [3:0] sel;
  logic [31:0] dat, rdat, obj_tx, done, req, base, q, v, eb;
  logic [2:0] mode;
  cfs_fifo_flags_t [31:0] flags;
  cfs_txq_ctrl_t transmit_queue;
  int error_cnt = 0;
  int tests_run = 0;

  cfs_top DUT (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .operating_mode_field(mode), .fifo_flags(flags), .object_is_transmitter(obj_tx),
    .send_done(done), .fifo_reset_done(rst_done), .send_request(req),
    .msg_mem_base(base), .txq_ctrl(transmit_queue), .head_tail_increment(hti));
  cfs_fifo_model far_end (.clk(clk), .rst(rst), .done_delay(delay), .send_request(req),
    .send_done(done));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic end_sim();
    if (error_cnt == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50)
      chk(32'h0000_0000, 32'h0000_0001);
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000);
    chk(q, exp);
  endtask : rd

  task automatic check_reset();
    rd(OFF_SEND_REQUEST, 32'h0000_0000);
    rd(OFF_MSG_MEM_BASE, 32'h0000_0000);
    rd(OFF_TXQ_CONTROL, 32'h0060_0480);
    chk({30'h0, transmit_queue.retransmit_attempts}, 32'h0000_0003);
    chk({31'h0, hti}, 32'h0000_0000);
  endtask : check_reset

  task automatic wait_idle();
    int n;
    n = 0;
    while (req !== 32'h0000_0000 && n < 200)
    begin
      @(posedge clk);
      n++;
    end
    chk(req, 32'h0000_0000);
  endtask : wait_idle

  // loads a flag pattern and checks all four summaries, also after writes to them
  task automatic summaries(input int p);
    cfs_fifo_flags_t f;
    logic [31:0] erx, eov, etx, eat;
    erx = 32'h0;
    eov = 32'h0;
    for (int i = 0; i < 32; i++)
    begin
      f = '{3'(i + p), 3'(i / 3 + p), i[1] ^ p[0], 3'(i / 2 + p), 3'(i * 5), i[0] ^ p[0]};
      flags[i] <= f;
      if (i > 0)
      begin
        erx[i] = |(f.rx_flags & f.rx_enables);
        eov[i] = f.rx_overflow_pending;
      end
      etx[i] = |(f.tx_flags & f.tx_enables);
      eat[i] = f.tx_attempt_pending;
    end
    for (int k = 0; k < 2; k++)
    begin
      rd(OFF_RX_PENDING, erx);
      rd(OFF_RX_OVERFLOW, eov);
      rd(OFF_TX_PENDING, etx);
      rd(OFF_TX_ATTEMPT, eat);
      for (int r = 0; r < 4; r++)
        wr(8'(r * 4), 32'hffff_ffff);
    end
  endtask : summaries

  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    end_sim();
  end

  initial
  begin
    rst = 1'b1;
    {cyc, stb, we, rst_done} = 4'h0;
    adr = 8'h00;
    sel = 4'hf;
    dat = 32'h0;
    mode = 3'h0;
    flags = '0;
    obj_tx = 32'h0;
    delay = 8'h1e;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    check_reset();
    summaries(0);
    summaries(1);
    for (int i = 0; i < 32; i++)
      flags[i].tx_attempt_pending <= 1'b0;
    rd(OFF_TX_ATTEMPT, 32'h0000_0000);
    obj_tx <= 32'h0000_fffe;
    wr(OFF_SEND_REQUEST, 32'hffff_ffff);
    rd(OFF_SEND_REQUEST, 32'h0000_ffff);
    wr(OFF_SEND_REQUEST, 32'h0000_0000);
    rd(OFF_SEND_REQUEST, 32'h0000_ffff);
    rd(OFF_TXQ_CONTROL, 32'h0060_0680);
    wait_idle();
    rd(OFF_SEND_REQUEST, 32'h0000_0000);
    delay <= 8'h01;
    wr(OFF_SEND_REQUEST, 32'h0000_0020);
    @(posedge clk);
    chk(req, 32'h0000_0020);
    wait_idle();
    rst_done <= 1'b1;
    @(posedge clk);
    rst_done <= 1'b0;
    rd(OFF_TXQ_CONTROL, 32'h0060_0080);
    eb = 32'h0;
    for (int m = 0; m < 8; m++)
    begin
      mode <= 3'(m);
      v = {8'(m + 1), 24'h5aa5f3};
      wr(OFF_MSG_MEM_BASE, v);
      if (m == 4)
        eb = v & 32'hffff_fffc;
      rd(OFF_MSG_MEM_BASE, eb);
      chk(base, eb);
    end
    wr(8'h1c, 32'hffff_ffff);
    rd(8'h1c, 32'h0000_0000);
    // queue control outside configuration mode: payload and depth stay locked
    delay <= 8'h1e;
    wr(OFF_TXQ_CONTROL, 32'hffff_ffff);
    @(posedge clk);
    chk({31'h0, hti}, 32'h0000_0001);
    rd(OFF_TXQ_CONTROL, 32'h007f_0695);
    wait_idle();
    mode <= MODE_CONFIG;
    wr(OFF_TXQ_CONTROL, 32'hff00_0000);
    rd(OFF_TXQ_CONTROL, 32'hff00_0480);
    wr(OFF_SEND_REQUEST, 32'h0000_0001);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    check_reset();
    end_sim();
  end
endmodule : tb_canfd_fifo_status_and_tx_request
`default_nettype wire
